//--- core/pmmd_decoder.sv
// Behaviour
// R1: pages 00h-04h single bank, 03h writable
// R2: page 10h writable, four lane banks
// R3: pages 11h and 19h read-only, lane banked
// R4: page 12h mixed access, lane banked
// R5: page 13h writable, 14h read-only, banked
// R6: pages 17h and 2Ch clear on read
// R7: page 1Ch bank count from advertisement
// R8: page 2Fh writable, lane banked
// R9: page 9Fh command page, two banks
// R10: pages A0h-AFh payload segments, two banks
// R11: reserved pages and banks are inaccessible
// R12: reserved bytes in supported pages addressable
// R13: reserved bytes always read as zero
// R14: reserved contents never evaluated nor altered
// R15: writes to reserved bytes are not stored
// R16: unsupported custom pages refuse all access
// R17: custom flags silent unless host aware
// R18: lane bank selects eight-lane group
// R19: clear-on-read byte cleared after read
// R20: bank beyond supported count is refused
module pmmd_decoder #(
  parameter int                LANE_BANKS     = pmmd_pkg::LANE_BANKS_DEF,
  parameter int                CMD_BANKS      = pmmd_pkg::CMD_BANKS_DEF,
  parameter logic              CUSTOM_SUPPORT = 1'b0,
  parameter int                CUSTOM_BANKS   = 1
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire pmmd_pkg::pmmd_req_type req,
  input  wire logic [7:0]             apps_bank_count,
  input  wire logic                   host_vendor_aware,
  input  wire logic [pmmd_pkg::CUSTOM_FLAG_W-1:0] custom_flags_in,
  output pmmd_pkg::pmmd_resp_type     resp,
  output logic [pmmd_pkg::CUSTOM_FLAG_W-1:0]      custom_flags_out
);

  typedef struct packed {
    pmmd_pkg::pmmd_resp_type          resp;
    logic [pmmd_pkg::CUSTOM_FLAG_W-1:0] flags;
  } pmmd_state_type;

  pmmd_state_type state;
  pmmd_state_type next_state;

  // page table: class and access type of each page number
  function automatic pmmd_pkg::pmmd_decode_type classify(
    input logic [7:0] page
  );
    pmmd_pkg::pmmd_decode_type d;
    d.cls = pmmd_pkg::PMMD_CLS_RESERVED;
    d.acc = pmmd_pkg::PMMD_ACC_NONE;
    // R1: unbanked administrative pages
    if (page <= pmmd_pkg::PG_LASER_ADV) begin
      d.cls = pmmd_pkg::PMMD_CLS_FIXED;
      d.acc = (page == pmmd_pkg::PG_USER_NV) ? pmmd_pkg::PMMD_ACC_RW
                                             : pmmd_pkg::PMMD_ACC_RO;
    end else if (page >= pmmd_pkg::PG_MON_FIRST &&
                 page <= pmmd_pkg::PG_MON_CTL) begin
      d.cls = pmmd_pkg::PMMD_CLS_LANE;
      d.acc = pmmd_pkg::PMMD_ACC_RO;
      // R6: monitor crossing flags clear on read
      if (page == pmmd_pkg::PG_MON_TC_FLAGS) begin
        d.acc = pmmd_pkg::PMMD_ACC_COR;
      end else if (page == pmmd_pkg::PG_MON_MASKS) begin
        d.acc = pmmd_pkg::PMMD_ACC_RW;
      // R8: monitor control page writable
      end else if (page == pmmd_pkg::PG_MON_CTL) begin
        d.acc = pmmd_pkg::PMMD_ACC_RW;
      // R11: a reserved page inside the banked range
      end else if (page == pmmd_pkg::PG_MON_RSVD) begin
        d.cls = pmmd_pkg::PMMD_CLS_RESERVED;
        d.acc = pmmd_pkg::PMMD_ACC_NONE;
      end
    // R9: command channel page
    end else if (page == pmmd_pkg::PG_CMD) begin
      d.cls = pmmd_pkg::PMMD_CLS_CMD;
      d.acc = pmmd_pkg::PMMD_ACC_RW;
    // R10: sixteen extended payload pages
    end else if (page >= pmmd_pkg::PG_PAYLOAD_LO &&
                 page <= pmmd_pkg::PG_PAYLOAD_HI) begin
      d.cls = pmmd_pkg::PMMD_CLS_PAYLOAD;
      d.acc = pmmd_pkg::PMMD_ACC_RW;
    // R16: vendor ranges, upper block and 1Eh-1Fh
    end else if (page >= pmmd_pkg::PG_CUSTOM_LO ||
                 page == pmmd_pkg::PG_VEND_LO ||
                 page == pmmd_pkg::PG_VEND_HI) begin
      d.cls = pmmd_pkg::PMMD_CLS_CUSTOM;
      d.acc = pmmd_pkg::PMMD_ACC_MIXED;
    end else begin
      // remaining low banked pages; others stay reserved
      case (page)
        // R2: lane configuration writable
        pmmd_pkg::PG_LANE_CFG,
        // R5: diagnostics control writable
        pmmd_pkg::PG_PERF_CTL,
        pmmd_pkg::PG_NET_PATH,
        pmmd_pkg::PG_CFG_EXT: begin
          d.cls = pmmd_pkg::PMMD_CLS_LANE;
          d.acc = pmmd_pkg::PMMD_ACC_RW;
        end
        // R3: status pages read-only
        pmmd_pkg::PG_LANE_STAT,
        pmmd_pkg::PG_STAT_EXT,
        // R5: diagnostics results read-only
        pmmd_pkg::PG_PERF_RES,
        pmmd_pkg::PG_TIMING: begin
          d.cls = pmmd_pkg::PMMD_CLS_LANE;
          d.acc = pmmd_pkg::PMMD_ACC_RO;
        end
        // R4: tunable laser, per-field access
        pmmd_pkg::PG_TUNE,
        pmmd_pkg::PG_SWITCH: begin
          d.cls = pmmd_pkg::PMMD_CLS_LANE;
          d.acc = pmmd_pkg::PMMD_ACC_MIXED;
        end
        // R6: lane flags clear on read
        pmmd_pkg::PG_LANE_FLAGS: begin
          d.cls = pmmd_pkg::PMMD_CLS_LANE;
          d.acc = pmmd_pkg::PMMD_ACC_COR;
        end
        // R7: normalized applications, read-only
        pmmd_pkg::PG_APPS: begin
          d.cls = pmmd_pkg::PMMD_CLS_APPS;
          d.acc = pmmd_pkg::PMMD_ACC_RO;
        end
        default: begin
          d.cls = pmmd_pkg::PMMD_CLS_RESERVED;
          d.acc = pmmd_pkg::PMMD_ACC_NONE;
        end
      endcase
    end
    return d;
  endfunction

  pmmd_pkg::pmmd_decode_type dec;
  logic                      bank_ok;

  // bank check per class; limits are counts, bank numbers start at 0
  always_comb begin
    dec = classify(req.page);
    unique case (dec.cls)
      // R1: single bank only
      pmmd_pkg::PMMD_CLS_FIXED:
        bank_ok = (req.bank == 8'h00);
      // R20: lane banks beyond population refused
      pmmd_pkg::PMMD_CLS_LANE:
        bank_ok = (32'(req.bank) < LANE_BANKS);
      // R7: advertised count, not a fixed figure
      pmmd_pkg::PMMD_CLS_APPS:
        bank_ok = (req.bank < apps_bank_count);
      // R9: one bank per command channel instance
      pmmd_pkg::PMMD_CLS_CMD,
      pmmd_pkg::PMMD_CLS_PAYLOAD:
        bank_ok = (32'(req.bank) < CMD_BANKS);
      // R16: only when the vendor function is built in
      pmmd_pkg::PMMD_CLS_CUSTOM:
        bank_ok = CUSTOM_SUPPORT && (32'(req.bank) < CUSTOM_BANKS);
      default:
        bank_ok = 1'b0;
    endcase
  end

  // verdict for the next cycle; a refused access stores and clears nothing
  always_comb begin
    next_state = state;
    next_state.resp.done = req.valid;
    next_state.resp.cls  = dec.cls;
    next_state.resp.acc  = dec.acc;
    // R11: reserved pages never granted
    next_state.resp.granted = req.valid && bank_ok &&
                              (dec.cls != pmmd_pkg::PMMD_CLS_RESERVED);
    // R12: reserved bytes inside a granted page stay addressable
    next_state.resp.force_zero = req.valid && bank_ok && !req.write &&
                                 req.reserved_byte &&
                                 (dec.cls != pmmd_pkg::PMMD_CLS_RESERVED);
    // R14: reserved contents never altered
    // R15: a write to a reserved byte is dropped
    next_state.resp.store_write = req.valid && bank_ok && req.write &&
                                  !req.reserved_byte &&
                                  (dec.acc == pmmd_pkg::PMMD_ACC_RW ||
                                   dec.acc == pmmd_pkg::PMMD_ACC_MIXED);
    // R19: read of a flag byte asks the flag logic to clear it
    next_state.resp.cor_clear = req.valid && bank_ok && !req.write &&
                                !req.reserved_byte &&
                                (dec.acc == pmmd_pkg::PMMD_ACC_COR);
    // R18: bank k covers lanes k*8+1 .. k*8+8
    next_state.resp.first_lane =
      6'(32'(req.bank[1:0]) * pmmd_pkg::LANES_PER_BANK + 1);
    // R10: one 128-byte segment per payload page
    next_state.resp.payload_index =
      11'(32'(req.page[3:0]) * pmmd_pkg::PAYLOAD_SEG_BYTES +
          32'(req.offset));
    // R17: vendor flags muted for a vendor-agnostic host
    next_state.flags = host_vendor_aware ? custom_flags_in
                                         : '0;
  end

  // the one state register; R13 zero start for everything
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign resp             = state.resp;
  assign custom_flags_out = state.flags;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // R11: reserved page numbers come back refused
  a_reserved_refused: assert property ( // R11
    req.valid && (req.page == pmmd_pkg::PG_MON_RSVD ||
                  (req.page > pmmd_pkg::PG_MON_CTL &&
                   req.page < pmmd_pkg::PG_CMD))
    |=> resp.done && !resp.granted && !resp.store_write)
    else $error("reserved page was granted");

  // R20: lane bank above population refused
  a_lane_bank_limit: assert property ( // R20
    req.valid && req.page == pmmd_pkg::PG_LANE_CFG &&
    32'(req.bank) >= LANE_BANKS
    |=> !resp.granted)
    else $error("unpopulated lane bank granted");

  // R2: populated lane config bank stores a write
  a_lane_cfg_write: assert property ( // R2
    req.valid && req.write && !req.reserved_byte &&
    req.page == pmmd_pkg::PG_LANE_CFG && 32'(req.bank) < LANE_BANKS
    |=> resp.granted && resp.store_write)
    else $error("lane config write not stored");

  // R3: read-only pages never store
  a_status_ro: assert property ( // R3
    req.valid && req.write &&
    (req.page == pmmd_pkg::PG_LANE_STAT || req.page == pmmd_pkg::PG_STAT_EXT)
    |=> resp.done && resp.acc == pmmd_pkg::PMMD_ACC_RO && !resp.store_write)
    else $error("read-only page stored a write");

  // R1: fixed pages only answer on bank zero
  a_fixed_single: assert property ( // R1
    req.valid && req.page <= pmmd_pkg::PG_LASER_ADV && req.bank != 8'h00
    |=> !resp.granted)
    else $error("fixed page granted on nonzero bank");

  // R9: command page bank count
  a_cmd_banks: assert property ( // R9
    req.valid && req.page == pmmd_pkg::PG_CMD
    |=> resp.granted == (32'($past(req.bank)) < CMD_BANKS))
    else $error("command bank decode wrong");

  // R15: reserved byte writes never reach storage
  a_rsvd_no_store: assert property ( // R15
    req.valid && req.write && req.reserved_byte |=> !resp.store_write)
    else $error("reserved byte write stored");

  // R13: granted reserved byte reads are forced to zero
  a_rsvd_zero: assert property ( // R13
    req.valid && !req.write && req.reserved_byte &&
    req.page == pmmd_pkg::PG_LANE_CFG && 32'(req.bank) < LANE_BANKS
    |=> resp.granted && resp.force_zero)
    else $error("reserved byte read not zeroed");

  // R19: granted flag byte read asks for a clear
  a_cor_clear: assert property ( // R19
    req.valid && !req.write && !req.reserved_byte &&
    req.page == pmmd_pkg::PG_LANE_FLAGS && 32'(req.bank) < LANE_BANKS
    |=> resp.done && resp.granted && resp.cor_clear)
    else $error("flag read did not clear");

  // R16: custom pages refused without vendor support
  a_custom_refused: assert property ( // R16
    req.valid && req.page >= pmmd_pkg::PG_CUSTOM_LO && !CUSTOM_SUPPORT
    |=> !resp.granted)
    else $error("custom page granted");

  // R17: flags silent once awareness has been low for two cycles
  a_custom_silent: assert property ( // R17
    !host_vendor_aware [*2] |=> custom_flags_out == '0)
    else $error("custom flag leaked");

  // R18: bank selects its eight-lane group
  a_lane_group: assert property ( // R18
    req.valid |=> resp.first_lane ==
      6'(32'($past(req.bank[1:0])) * pmmd_pkg::LANES_PER_BANK + 1))
    else $error("lane group wrong");

  // R1: user store page takes writes on bank zero
  a_user_nv_write: assert property ( // R1
    req.valid && req.write && !req.reserved_byte &&
    req.page == pmmd_pkg::PG_USER_NV && req.bank == 8'h00
    |=> resp.granted && resp.store_write)
    else $error("user store write not stored");

  // R4: tunable laser page has per-field access
  a_tune_mixed: assert property ( // R4
    req.valid && req.page == pmmd_pkg::PG_TUNE
    |=> resp.acc == pmmd_pkg::PMMD_ACC_MIXED)
    else $error("tune page access wrong");

  // R5: diagnostics control page writable
  a_perf_ctl_rw: assert property ( // R5
    req.valid && req.page == pmmd_pkg::PG_PERF_CTL
    |=> resp.acc == pmmd_pkg::PMMD_ACC_RW)
    else $error("diagnostics control access wrong");

  // R5: diagnostics results page read-only
  a_perf_res_ro: assert property ( // R5
    req.valid && req.page == pmmd_pkg::PG_PERF_RES
    |=> resp.acc == pmmd_pkg::PMMD_ACC_RO)
    else $error("diagnostics results access wrong");

  // R6: both flag pages clear on read
  a_flag_pages_cor: assert property ( // R6
    req.valid && (req.page == pmmd_pkg::PG_LANE_FLAGS ||
                  req.page == pmmd_pkg::PG_MON_TC_FLAGS)
    |=> resp.acc == pmmd_pkg::PMMD_ACC_COR)
    else $error("flag page access wrong");

  // R7: application bank limit follows advertisement
  a_apps_banks: assert property ( // R7
    req.valid && req.page == pmmd_pkg::PG_APPS
    |=> resp.granted == ($past(req.bank) < $past(apps_bank_count)))
    else $error("application bank decode wrong");

  // R10: payload banks limited like the command page
  a_payload_banks: assert property ( // R10
    req.valid && req.page >= pmmd_pkg::PG_PAYLOAD_LO &&
    req.page <= pmmd_pkg::PG_PAYLOAD_HI
    |=> resp.granted == (32'($past(req.bank)) < CMD_BANKS))
    else $error("payload bank decode wrong");

  // R10: segment index is page slot then byte offset
  a_payload_index: assert property ( // R10
    req.valid |=> resp.payload_index ==
      {$past(req.page[3:0]), $past(req.offset)})
    else $error("payload index wrong");

  // R16: vendor pages 1Eh-1Fh refused without support
  a_vendor_refused: assert property ( // R16
    req.valid && !CUSTOM_SUPPORT &&
    (req.page == pmmd_pkg::PG_VEND_LO || req.page == pmmd_pkg::PG_VEND_HI)
    |=> !resp.granted && !resp.store_write)
    else $error("vendor page granted");

  // R19: a write never triggers a clear
  a_write_no_clear: assert property ( // R19
    req.valid && req.write |=> !resp.cor_clear)
    else $error("write requested a clear");

endmodule

//--- core/pmmd_pkg.sv
package pmmd_pkg;

  // bank population and page geometry
  localparam int LANE_BANKS_DEF    = 4;
  localparam int CMD_BANKS_DEF     = 2;
  localparam int LANES_PER_BANK    = 8;
  localparam int APPS_PER_BANK     = 15;
  localparam int PAYLOAD_SEG_BYTES = 128;
  localparam int CUSTOM_FLAG_W     = 8;

  // page numbers that bound the classes
  localparam logic [7:0] PG_ADMIN        = 8'h00;
  localparam logic [7:0] PG_USER_NV      = 8'h03;
  localparam logic [7:0] PG_LASER_ADV    = 8'h04;
  localparam logic [7:0] PG_LANE_CFG     = 8'h10;
  localparam logic [7:0] PG_LANE_STAT    = 8'h11;
  localparam logic [7:0] PG_TUNE         = 8'h12;
  localparam logic [7:0] PG_PERF_CTL     = 8'h13;
  localparam logic [7:0] PG_PERF_RES     = 8'h14;
  localparam logic [7:0] PG_TIMING       = 8'h15;
  localparam logic [7:0] PG_NET_PATH     = 8'h16;
  localparam logic [7:0] PG_LANE_FLAGS   = 8'h17;
  localparam logic [7:0] PG_CFG_EXT      = 8'h18;
  localparam logic [7:0] PG_STAT_EXT     = 8'h19;
  localparam logic [7:0] PG_APPS         = 8'h1C;
  localparam logic [7:0] PG_SWITCH       = 8'h1D;
  localparam logic [7:0] PG_VEND_LO      = 8'h1E;
  localparam logic [7:0] PG_VEND_HI      = 8'h1F;
  localparam logic [7:0] PG_MON_FIRST    = 8'h20;
  localparam logic [7:0] PG_MON_LAST_RO  = 8'h2B;
  localparam logic [7:0] PG_MON_TC_FLAGS = 8'h2C;
  localparam logic [7:0] PG_MON_MASKS    = 8'h2D;
  localparam logic [7:0] PG_MON_RSVD     = 8'h2E;
  localparam logic [7:0] PG_MON_CTL      = 8'h2F;
  localparam logic [7:0] PG_CMD          = 8'h9F;
  localparam logic [7:0] PG_PAYLOAD_LO   = 8'hA0;
  localparam logic [7:0] PG_PAYLOAD_HI   = 8'hAF;
  localparam logic [7:0] PG_CUSTOM_LO    = 8'hB0;

  typedef enum logic [2:0] {
    PMMD_CLS_RESERVED = 3'b000,
    PMMD_CLS_FIXED    = 3'b001,
    PMMD_CLS_LANE     = 3'b010,
    PMMD_CLS_APPS     = 3'b011,
    PMMD_CLS_CMD      = 3'b100,
    PMMD_CLS_PAYLOAD  = 3'b101,
    PMMD_CLS_CUSTOM   = 3'b110
  } pmmd_class_type;

  typedef enum logic [2:0] {
    PMMD_ACC_NONE  = 3'b000,
    PMMD_ACC_RO    = 3'b001,
    PMMD_ACC_RW    = 3'b010,
    PMMD_ACC_COR   = 3'b011,
    PMMD_ACC_MIXED = 3'b100
  } pmmd_access_type;

  typedef struct packed {
    pmmd_class_type  cls;
    pmmd_access_type acc;
  } pmmd_decode_type;

  // one access from the two-wire front end
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] page;
    logic [7:0] bank;
    logic [6:0] offset;
    logic       reserved_byte;
  } pmmd_req_type;

  // verdict on that access, one cycle later
  typedef struct packed {
    logic            done;
    logic            granted;
    logic            store_write;
    logic            force_zero;
    logic            cor_clear;
    pmmd_class_type  cls;
    pmmd_access_type acc;
    logic [5:0]      first_lane;
    logic [10:0]     payload_index;
  } pmmd_resp_type;

endpackage

//--- tb/pmmd_host_model.sv
module pmmd_host_model (
  input  wire logic                    clock,
  output pmmd_pkg::pmmd_req_type       req,
  input  wire pmmd_pkg::pmmd_resp_type resp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle host, no access pending
  initial req = '0;

  // one byte access: held over one rising edge, answer one cycle later
  // host access policy
  task automatic access(input logic w, input logic [7:0] pg, bk,
                        input logic [6:0] off, input logic rb,
                        output pmmd_pkg::pmmd_resp_type r);
    pmmd_pkg::pmmd_req_type nxt;
    @(negedge clock);
    nxt = {1'b1, w, pg, bk, off, rb};
    req = nxt;
    @(negedge clock);
    r = resp;
    // released lines do not keep their last value
    nxt = ~req;
    nxt.valid = 1'b0;
    req = nxt;
  endtask
endmodule

//--- tb/pmmd_testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                               clock = 1'b0;
  logic                               reset_n = 1'b0;
  logic [7:0]                         apps_bank_count = 8'h04;
  logic                               host_vendor_aware = 1'b0;
  logic [pmmd_pkg::CUSTOM_FLAG_W-1:0] custom_flags_in = '0;
  logic [pmmd_pkg::CUSTOM_FLAG_W-1:0] custom_flags_out;
  pmmd_pkg::pmmd_req_type             req;
  pmmd_pkg::pmmd_resp_type            resp;
  pmmd_pkg::pmmd_resp_type            r;
  int                                 n_mismatch = 0;
  int                                 checks = 0;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  pmmd_decoder i_dut (
    .clock            (clock),
    .reset_n          (reset_n),
    .req              (req),
    .apps_bank_count  (apps_bank_count),
    .host_vendor_aware(host_vendor_aware),
    .custom_flags_in  (custom_flags_in),
    .resp             (resp),
    .custom_flags_out (custom_flags_out)
  );

  pmmd_host_model i_host (
    .clock(clock),
    .req  (req),
    .resp (resp)
  );

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // e packs granted, store_write, force_zero, cor_clear
  task automatic go(input logic w, input logic [7:0] pg, bk,
                    input logic [6:0] off, input logic rb,
                    input logic [3:0] e);
    i_host.access(w, pg, bk, off, rb, r);
    chk(16'({r.done, r.granted, r.store_write, r.force_zero,
             r.cor_clear}), 16'({1'b1, e}), "verdict");
  endtask

  task automatic t_fixed;
    for (int p = 0; p < 5; p++) begin
      go(1'b0, 8'(p), 8'h00, 7'h00, 1'b0, 4'h8);
      chk(16'(r.acc), (p == 3) ? 16'(pmmd_pkg::PMMD_ACC_RW)
                               : 16'(pmmd_pkg::PMMD_ACC_RO), "acc");
      go(1'b1, 8'(p), 8'h00, 7'h01, 1'b0, {1'b1, p == 3, 2'b00});
      go(1'b0, 8'(p), 8'h01, 7'h00, 1'b0, 4'h0);
    end
    $display("test fixed done");
  endtask

  task automatic t_lane;
    logic [7:0] pg[9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19,
                          8'h2F, 8'h17, 8'h2C};
    logic [2:0] ac[9] = '{3'h2, 3'h1, 3'h4, 3'h2, 3'h1, 3'h1, 3'h2,
                          3'h3, 3'h3};
    logic ok;
    logic rw;
    logic cr;
    for (int i = 0; i < 9; i++) begin
      for (int b = 0; b < 5; b++) begin
        ok = (b < 4);
        rw = ok && (ac[i] == 3'h2 || ac[i] == 3'h4);
        cr = ok && (ac[i] == 3'h3);
        go(1'b0, pg[i], 8'(b), 7'h05, 1'b0, {ok, 2'b00, cr});
        if (ok) begin
          chk(16'(r.acc), 16'(ac[i]), "acc");
          chk(16'(r.cls), 16'(pmmd_pkg::PMMD_CLS_LANE), "cls");
          chk(16'(r.first_lane), 16'(b * 8 + 1), "lane");
        end
        go(1'b1, pg[i], 8'(b), 7'h7F, 1'b0, {ok, rw, 2'b00});
      end
    end
    $display("test lane done");
  endtask

  task automatic t_apps;
    @(negedge clock);
    apps_bank_count = 8'h03;
    go(1'b0, 8'h1C, 8'h02, 7'h00, 1'b0, 4'h8);
    chk(16'(r.acc), 16'(pmmd_pkg::PMMD_ACC_RO), "acc");
    chk(16'(r.cls), 16'(pmmd_pkg::PMMD_CLS_APPS), "cls");
    go(1'b0, 8'h1C, 8'h03, 7'h00, 1'b0, 4'h0);
    $display("test apps done");
  endtask

  task automatic t_cmd;
    go(1'b1, 8'h9F, 8'h01, 7'h10, 1'b0, 4'hC);
    go(1'b0, 8'h9F, 8'h02, 7'h10, 1'b0, 4'h0);
    for (int p = 8'hA0; p <= 8'hAF; p++) begin
      go(1'b1, 8'(p), 8'h01, 7'h7F, 1'b0, 4'hC);
      chk(16'(r.payload_index), 16'({p[3:0], 7'h7F}), "index");
    end
    go(1'b0, 8'hA5, 8'h02, 7'h00, 1'b0, 4'h0);
    $display("test cmd done");
  endtask

  task automatic t_reserved;
    logic [7:0] pg[11] = '{8'h05, 8'h0C, 8'h1A, 8'h2E, 8'h30, 8'h60,
                           8'h9E, 8'h1E, 8'h1F, 8'hB0, 8'hFF};
    for (int i = 0; i < 11; i++) begin
      go(1'b0, pg[i], 8'h00, 7'h00, 1'b0, 4'h0);
      go(1'b1, pg[i], 8'h00, 7'h00, 1'b0, 4'h0);
    end
    go(1'b0, 8'h10, 8'h00, 7'h20, 1'b1, 4'hA);
    go(1'b1, 8'h10, 8'h00, 7'h20, 1'b1, 4'h8);
    go(1'b0, 8'h17, 8'h00, 7'h20, 1'b1, 4'hA);
    $display("test reserved done");
  endtask

  task automatic t_flags;
    go(1'b0, 8'h00, 8'h00, 7'h00, 1'b0, 4'h8);
    @(negedge clock);
    chk(16'(resp.done), 16'h0000, "done");
    custom_flags_in = 8'hA5;
    @(negedge clock);
    @(negedge clock);
    chk(16'(custom_flags_out), 16'h0000, "silent");
    host_vendor_aware = 1'b1;
    @(negedge clock);
    chk(16'(custom_flags_out), 16'h00A5, "aware");
    host_vendor_aware = 1'b0;
    @(negedge clock);
    chk(16'(custom_flags_out), 16'h0000, "silent");
    $display("test flags done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence, reset held five cycles
  initial begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    t_fixed();
    t_lane();
    t_apps();
    t_cmd();
    t_reserved();
    t_flags();
    summarize();
  end

  // run needs under 1000 cycles; cut a hang well beyond that
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule
